// ---- verilog/verifier_pkg.sv ----
// Functional notes
// (RULE1) width select bit picks 16 or 20-bit word
// (RULE2) length field picks the pseudo-random polynomial
// (RULE3) select field: off, random, clock, custom, timing
// (RULE4) custom word in three bytes, nibble when wide
// (RULE5) deskew done status reads high when aligned
// (RULE6) counter clear acts on rising edge only
// (RULE7) latched per-lane flags, cleared by clear bit
// (RULE8) three-bit selector picks the flag event source
// (RULE9) four per-lane data-path check enable bits
// (RULE10) data-path error source field encodings
// (RULE11) data-path event feeds lane 0 count, flags
// (RULE12) live per-lane flags in bits 3:0
// (RULE13) controls pass while strobe high, held after
// (RULE14) per-lane mismatch detected status bit
// (RULE15) per-lane error count readable, low and high
// (RULE16) reserved bits read zero, writes ignored
// (RULE17) host configures before strobe, clears before test
`default_nettype none
package verifier_pkg;
    // ==========================================================
    // sizes
    localparam int LANES = 4;
    localparam int CNT_W = 12;
    localparam int COUNT_LOW_W = 8;
    localparam int HIST_W = 31;
    localparam int SYNC_W = 31;
    localparam int RUN_W = 4;
    localparam int IDX_W = 5;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_LOAD = 8'h0E;
    localparam logic [7:0] ADDR_LANE_STAT = 8'h0F;
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_CUSTOM_LOW = 8'h11;
    localparam logic [7:0] ADDR_CUSTOM_MID = 8'h12;
    localparam logic [7:0] ADDR_CUSTOM_TOP = 8'h13;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h14;
    localparam logic [7:0] ADDR_CLEAR_SEL = 8'h15;
    localparam logic [7:0] ADDR_DP_CTRL = 8'h16;
    localparam logic [7:0] ADDR_FLAGS = 8'h17;
    localparam logic [7:0] ADDR_COUNT_BASE = 8'h18;

    // ==========================================================
    // field positions
    localparam int WIDTH_SEL_BIT = 7;
    localparam int LEN_LSB = 3;
    localparam int LANE_HI_LSB = 4;
    localparam int DESKEW_BIT = 7;
    localparam int CNT_CLR_BIT = 4;
    localparam int FLAG_CLR_BIT = 3;

    // ==========================================================
    // encodings
    localparam logic [2:0] PAT_OFF = 3'h0;
    localparam logic [2:0] PAT_PRBS = 3'h1;
    localparam logic [2:0] PAT_CLOCK = 3'h2;
    localparam logic [2:0] PAT_CUSTOM = 3'h3;

    localparam logic [2:0] LEN_7 = 3'h0;
    localparam logic [2:0] LEN_11 = 3'h1;
    localparam logic [2:0] LEN_23 = 3'h2;
    localparam logic [2:0] LEN_31 = 3'h3;
    localparam logic [2:0] LEN_15A = 3'h4;
    localparam logic [2:0] LEN_15B = 3'h5;
    localparam logic [2:0] LEN_20A = 3'h6;
    localparam logic [2:0] LEN_20B = 3'h7;

    localparam logic [2:0] DP_DISPARITY = 3'h0;
    localparam logic [2:0] DP_FIFO_ERR = 3'h1;
    localparam logic [2:0] DP_OVERFLOW = 3'h2;
    localparam logic [2:0] DP_UNDERFLOW = 3'h3;
    localparam logic [2:0] DP_DESKEW = 3'h4;

    localparam logic [2:0] TST_BIT_ERROR = 3'h0;
    localparam logic [2:0] TST_SYNC = 3'h1;
    localparam logic [2:0] TST_TRAINING = 3'h2;
    localparam logic [2:0] TST_MISMATCH = 3'h3;
    localparam logic [2:0] TST_SATURATED = 3'h4;

    // polynomial order and second tap per length
    localparam logic [4:0] ORD_7 = 5'h07;
    localparam logic [4:0] TAP_7 = 5'h06;
    localparam logic [4:0] ORD_11 = 5'h0B;
    localparam logic [4:0] TAP_11 = 5'h09;
    localparam logic [4:0] ORD_15 = 5'h0F;
    localparam logic [4:0] TAP_15 = 5'h0E;
    localparam logic [4:0] ORD_20 = 5'h14;
    localparam logic [4:0] TAP_20 = 5'h03;
    localparam logic [4:0] ORD_23 = 5'h17;
    localparam logic [4:0] TAP_23 = 5'h12;
    localparam logic [4:0] ORD_31 = 5'h1F;
    localparam logic [4:0] TAP_31 = 5'h1C;

    localparam logic [IDX_W-1:0] CUSTOM_LAST_16 = 5'h0F;
    localparam logic [IDX_W-1:0] CUSTOM_LAST_20 = 5'h13;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [2:0] pattern_type_sel;
        logic [2:0] prbs_length_sel;
        logic custom_width_sel;
        logic [19:0] custom_word;
        logic [2:0] retain_threshold;
    } lane_cfg_type;

    typedef struct packed {
        logic [3:0] disparity;
        logic [3:0] fifo_err;
        logic [3:0] overflow;
        logic [3:0] underflow;
        logic [3:0] deskew;
    } dp_events_type;
endpackage
`default_nettype wire

// ---- verilog/error_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module error_counter #(
    parameter int WIDTH = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic inc,
    output logic [WIDTH-1:0] count,
    output logic saturated
);
    import verifier_pkg::*;

    logic [WIDTH-1:0] count_q;

    // an error in the clearing cycle is kept as the first count
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_q <= '0;
        else if (clear)
            count_q <= WIDTH'(inc); // RULE6
        else if (inc && !(&count_q))
            count_q <= count_q + 1'b1;
    end

    assign count = count_q;
    assign saturated = &count_q;
endmodule
`default_nettype wire

// ---- verilog/lane_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module lane_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire verifier_pkg::lane_cfg_type cfg_in,
    input wire logic rx_bit,
    output logic bit_error,
    output logic sync_pulse,
    output logic training,
    output logic mismatch
);
    import verifier_pkg::*;

    lane_cfg_type cfg_q;
    logic [HIST_W-1:0] hist_q;
    logic [IDX_W-1:0] idx_q;
    logic [RUN_W-1:0] run_q;
    logic [SYNC_W-1:0] sync_q;
    logic [4:0] order;
    logic [4:0] tap_b;
    logic [31:0] period_m2;
    logic [IDX_W-1:0] idx_last;
    logic compare_on;
    logic expected;
    logic miss;
    logic locked;

    // ==========================================================
    // configuration capture
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cfg_q <= '0;
        else if (load)
            cfg_q <= cfg_in; // RULE13
    end

    // ==========================================================
    // expected bit
    always_comb
    begin
        unique case (cfg_q.prbs_length_sel) // RULE2
            LEN_7:
            begin
                order = ORD_7;
                tap_b = TAP_7;
            end
            LEN_11:
            begin
                order = ORD_11;
                tap_b = TAP_11;
            end
            LEN_23:
            begin
                order = ORD_23;
                tap_b = TAP_23;
            end
            LEN_31:
            begin
                order = ORD_31;
                tap_b = TAP_31;
            end
            LEN_15A, LEN_15B:
            begin
                order = ORD_15;
                tap_b = TAP_15;
            end
            LEN_20A, LEN_20B:
            begin
                order = ORD_20;
                tap_b = TAP_20;
            end
        endcase
    end

    assign idx_last = cfg_q.custom_width_sel ? CUSTOM_LAST_20
                                             : CUSTOM_LAST_16; // RULE1 RULE4
    // off and timing-only codes compare nothing
    assign compare_on = cfg_q.pattern_type_sel inside
                        {PAT_PRBS, PAT_CLOCK, PAT_CUSTOM}; // RULE3

    always_comb
    begin
        unique case (cfg_q.pattern_type_sel) // RULE3
            PAT_PRBS:
                expected = hist_q[order - 5'h01] ^ hist_q[tap_b - 5'h01];
            PAT_CLOCK:
                expected = ~hist_q[0];
            PAT_CUSTOM:
                expected = cfg_q.custom_word[idx_q]; // RULE4
            default:
                expected = 1'b0;
        endcase
    end

    assign miss = compare_on && (rx_bit != expected);
    assign locked = run_q > {1'b0, cfg_q.retain_threshold};
    assign period_m2 = (32'h1 << order) - 32'h2;

    // ==========================================================
    // history, custom index and training run
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            hist_q <= '0;
        else
            hist_q <= {hist_q[HIST_W-2:0], rx_bit};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            idx_q <= '0;
        else if (load || (miss && !locked) || idx_q >= idx_last)
            idx_q <= '0;
        else
            idx_q <= idx_q + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            run_q <= '0;
        else if (load || !compare_on || (miss && !locked))
            run_q <= '0;
        else if (!locked)
            run_q <= run_q + 1'b1;
    end

    // ==========================================================
    // sync pulse once per PRBS period of the selected length
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sync_q <= '0;
        else if (load || cfg_q.pattern_type_sel == PAT_OFF)
            sync_q <= '0;
        else if (sync_q >= period_m2[SYNC_W-1:0])
            sync_q <= '0;
        else
            sync_q <= sync_q + 1'b1;
    end

    // ==========================================================
    // lane status
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_error <= 1'b0;
            sync_pulse <= 1'b0;
            training <= 1'b0;
        end
        else
        begin
            bit_error <= miss && locked;
            sync_pulse <= (cfg_q.pattern_type_sel != PAT_OFF)
                          && (sync_q >= period_m2[SYNC_W-1:0]);
            training <= compare_on && !locked;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mismatch <= 1'b0;
        else if (miss && locked)
            mismatch <= 1'b1; // RULE14
        else if (load)
            mismatch <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- verilog/rx_lane_pattern_verifier.sv ----
`timescale 1ns/1ps
`default_nettype none
module rx_lane_pattern_verifier (
    input wire logic clk,
    input wire logic rst_b,
    input wire verifier_pkg::reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] rx_bits,
    input wire verifier_pkg::dp_events_type dp_events,
    input wire logic deskew_complete,
    output logic [3:0] live_test_flag,
    output logic [3:0] latched_test_flag
);
    import verifier_pkg::*;

    // ==========================================================
    // control registers
    logic [3:0] lane_load_strobe_q;
    logic [2:0] pattern_type_sel_q;
    logic [2:0] prbs_length_sel_q;
    logic custom_width_sel_q;
    logic [19:0] custom_word_q;
    logic [2:0] retain_threshold_q;
    logic error_counter_clear_q;
    logic clear_prev_q;
    logic latched_flag_clear_q;
    logic [2:0] test_irq_source_sel_q;
    logic [3:0] datapath_check_enable_q;
    logic [2:0] datapath_error_source_q;
    logic deskew_done_q;
    logic [3:0] live_q;
    logic [3:0] latched_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;
    logic [7:0] wd;
    lane_cfg_type lane_cfg;
    logic counter_clear;

    assign wd = reg_req.wdata;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            lane_load_strobe_q <= 4'h0;
        else if (reg_req.wr && reg_req.addr == ADDR_LOAD)
            lane_load_strobe_q <= wd[3:0];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            custom_width_sel_q <= 1'b0;
            prbs_length_sel_q <= 3'h0;
            pattern_type_sel_q <= 3'h0;
        end
        else if (reg_req.wr && reg_req.addr == ADDR_MODE)
        begin
            custom_width_sel_q <= wd[WIDTH_SEL_BIT]; // RULE1
            prbs_length_sel_q <= wd[LEN_LSB +: 3]; // RULE2
            pattern_type_sel_q <= wd[2:0]; // RULE3
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            custom_word_q <= 20'h00000;
        else if (reg_req.wr && reg_req.addr == ADDR_CUSTOM_LOW)
            custom_word_q[7:0] <= wd; // RULE4
        else if (reg_req.wr && reg_req.addr == ADDR_CUSTOM_MID)
            custom_word_q[15:8] <= wd; // RULE4
        else if (reg_req.wr && reg_req.addr == ADDR_CUSTOM_TOP)
            custom_word_q[19:16] <= wd[3:0]; // RULE4 RULE16
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            retain_threshold_q <= 3'h0;
        else if (reg_req.wr && reg_req.addr == ADDR_THRESHOLD)
            retain_threshold_q <= wd[2:0]; // RULE16
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            error_counter_clear_q <= 1'b0;
            test_irq_source_sel_q <= 3'h0;
        end
        else if (reg_req.wr && reg_req.addr == ADDR_CLEAR_SEL)
        begin
            error_counter_clear_q <= wd[CNT_CLR_BIT];
            test_irq_source_sel_q <= wd[2:0]; // RULE8
        end
    end

    // flag clear is a one-cycle self-clearing command
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            latched_flag_clear_q <= 1'b0;
        else
            latched_flag_clear_q <= reg_req.wr
                && reg_req.addr == ADDR_CLEAR_SEL
                && wd[FLAG_CLR_BIT]; // RULE7
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clear_prev_q <= 1'b0;
        else
            clear_prev_q <= error_counter_clear_q;
    end

    assign counter_clear = error_counter_clear_q && !clear_prev_q; // RULE6

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            datapath_check_enable_q <= 4'h0;
            datapath_error_source_q <= 3'h0;
        end
        else if (reg_req.wr && reg_req.addr == ADDR_DP_CTRL)
        begin
            datapath_check_enable_q <= wd[LANE_HI_LSB +: 4]; // RULE9
            datapath_error_source_q <= wd[2:0]; // RULE10
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            deskew_done_q <= 1'b0;
        else
            deskew_done_q <= deskew_complete; // RULE5
    end

    // ==========================================================
    // lanes
    assign lane_cfg.pattern_type_sel = pattern_type_sel_q;
    assign lane_cfg.prbs_length_sel = prbs_length_sel_q;
    assign lane_cfg.custom_width_sel = custom_width_sel_q;
    assign lane_cfg.custom_word = custom_word_q;
    assign lane_cfg.retain_threshold = retain_threshold_q;

    logic [3:0] bit_error;
    logic [3:0] sync_pulse;
    logic [3:0] training;
    logic [3:0] mismatch;
    logic [3:0] saturated;
    logic [3:0] count_inc;
    logic [3:0] test_event;
    logic [3:0] dp_selected;
    logic dp_active;
    logic dp_event;
    logic [CNT_W-1:0] count [LANES];

    always_comb
    begin
        unique case (datapath_error_source_q) // RULE10
            DP_DISPARITY:
                dp_selected = dp_events.disparity;
            DP_FIFO_ERR:
                dp_selected = dp_events.fifo_err;
            DP_OVERFLOW:
                dp_selected = dp_events.overflow;
            DP_UNDERFLOW:
                dp_selected = dp_events.underflow;
            DP_DESKEW:
                dp_selected = dp_events.deskew;
            default:
                dp_selected = 4'h0;
        endcase
    end

    assign dp_active = |datapath_check_enable_q; // RULE11
    assign dp_event = |(dp_selected & datapath_check_enable_q); // RULE9

    genvar n;
    generate
        for (n = 0; n < LANES; n++)
        begin : g_lane
            logic own_event;

            lane_checker lane (
                .clk(clk),
                .rst_b(rst_b),
                .load(lane_load_strobe_q[n]),
                .cfg_in(lane_cfg),
                .rx_bit(rx_bits[n]),
                .bit_error(bit_error[n]),
                .sync_pulse(sync_pulse[n]),
                .training(training[n]),
                .mismatch(mismatch[n])
            );

            if (n == 0)
            begin : g_dp
                assign count_inc[n] = dp_active ? dp_event
                                                : bit_error[n]; // RULE11
            end
            else
            begin : g_plain
                assign count_inc[n] = bit_error[n];
            end

            error_counter #(
                .WIDTH(CNT_W)
            ) counter (
                .clk(clk),
                .rst_b(rst_b),
                .clear(counter_clear),
                .inc(count_inc[n]),
                .count(count[n]),
                .saturated(saturated[n])
            ); // RULE15

            always_comb
            begin
                unique case (test_irq_source_sel_q) // RULE8
                    TST_BIT_ERROR:
                        own_event = bit_error[n];
                    TST_SYNC:
                        own_event = sync_pulse[n];
                    TST_TRAINING:
                        own_event = training[n];
                    TST_MISMATCH:
                        own_event = mismatch[n];
                    TST_SATURATED:
                        own_event = saturated[n];
                    default:
                        own_event = 1'b0;
                endcase
            end

            if (n == 0)
            begin : g_dp_evt
                assign test_event[n] = dp_active ? dp_event
                                                 : own_event; // RULE11
            end
            else
            begin : g_own_evt
                assign test_event[n] = own_event;
            end
        end
    endgenerate

    // ==========================================================
    // test flags
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            live_q <= 4'h0;
        else
            live_q <= test_event; // RULE12
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            latched_q <= 4'h0;
        else
            latched_q <= (latched_q & ~{4{latched_flag_clear_q}})
                         | test_event; // RULE7
    end

    assign live_test_flag = live_q;
    assign latched_test_flag = latched_q;

    // ==========================================================
    // read back
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (reg_req.addr) // RULE16
            ADDR_LOAD:
                rd_mux = {sync_pulse, lane_load_strobe_q};
            ADDR_LANE_STAT:
                rd_mux = {mismatch, training}; // RULE14
            ADDR_MODE:
                rd_mux = {custom_width_sel_q, 1'b0, prbs_length_sel_q,
                          pattern_type_sel_q};
            ADDR_CUSTOM_LOW:
                rd_mux = custom_word_q[7:0];
            ADDR_CUSTOM_MID:
                rd_mux = custom_word_q[15:8];
            ADDR_CUSTOM_TOP:
                rd_mux = {4'h0, custom_word_q[19:16]};
            ADDR_THRESHOLD:
                rd_mux = {5'h00, retain_threshold_q};
            ADDR_CLEAR_SEL:
                rd_mux = {deskew_done_q, 2'h0, error_counter_clear_q,
                          latched_flag_clear_q, test_irq_source_sel_q}; // RULE5
            ADDR_DP_CTRL:
                rd_mux = {datapath_check_enable_q, 1'b0,
                          datapath_error_source_q};
            ADDR_FLAGS:
                rd_mux = {latched_q, live_q}; // RULE7 RULE12
            default:
                rd_mux = 8'h00;
        endcase
        for (int i = 0; i < LANES; i++)
        begin
            if (reg_req.addr == ADDR_COUNT_BASE + 8'(2 * i))
                rd_mux = count[i][COUNT_LOW_W-1:0]; // RULE15
            if (reg_req.addr == ADDR_COUNT_BASE + 8'(2 * i + 1))
                rd_mux = 8'(count[i] >> COUNT_LOW_W); // RULE15
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else if (reg_req.rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ---- verification/verifier_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module verifier_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire verifier_pkg::reg_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic deskew_complete,
    input wire logic [3:0] live_test_flag,
    input wire logic [3:0] latched_test_flag
);
    import verifier_pkg::*;
    logic [2:0] age_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // cycles since the last flag clear write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            age_q <= 3'h7;
        else if (reg_req.wr && reg_req.addr == ADDR_CLEAR_SEL
                 && reg_req.wdata[3])
            age_q <= 3'h0;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end
    property p_sticky;
        |($past(latched_test_flag) & ~latched_test_flag) |-> age_q < 3'h4;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_live_in;
        (live_test_flag & ~latched_test_flag) == 4'h0;
    endproperty
    a_live_in: assert property (p_live_in) else $error("live unlatched");
    property p_unmapped;
        reg_req.rd && reg_req.addr > 8'h1F |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_hold;
        !reg_req.rd |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_rsvd_top;
        reg_req.rd && reg_req.addr inside {8'h13, 8'h14}
            |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_rsvd_top: assert property (p_rsvd_top) else $error("rsvd");
    property p_rsvd_dp;
        reg_req.rd && reg_req.addr == ADDR_DP_CTRL |=> !reg_rdata[3];
    endproperty
    a_rsvd_dp: assert property (p_rsvd_dp) else $error("rsvd dp");
    property p_deskew;
        reg_req.rd && reg_req.addr == ADDR_CLEAR_SEL
            |=> reg_rdata[7] == $past(deskew_complete, 2);
    endproperty
    a_deskew: assert property (p_deskew) else $error("deskew");
    property p_cnt_top;
        reg_req.rd && reg_req.addr[7:3] == 5'h03 && reg_req.addr[0]
            |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_cnt_top: assert property (p_cnt_top) else $error("count top");
    c_latched: cover property (|latched_test_flag);
    c_cleared: cover property ($fell(latched_test_flag[0]));
    c_count: cover property (reg_req.rd && reg_req.addr == ADDR_COUNT_BASE);
endmodule
bind rx_lane_pattern_verifier verifier_monitor mon (
    .clk(clk),
    .rst_b(rst_b),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .deskew_complete(deskew_complete),
    .live_test_flag(live_test_flag),
    .latched_test_flag(latched_test_flag)
);
`default_nettype wire

// ---- verification/pattern_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module pattern_source (
    input wire logic clk,
    input wire logic [19:0] word,
    input wire logic wide,
    input wire logic flip,
    output logic bit_out
);
    int idx = 0;
    // custom word sent lsb first; flip corrupts one bit
    always @(posedge clk)
    begin
        bit_out <= word[idx] ^ flip;
        idx <= (idx >= (wide ? 19 : 15)) ? 0 : idx + 1;
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import verifier_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    reg_req_type reg_req = '0;
    dp_events_type dp_events = '0;
    logic deskew_complete = 0;
    logic wide = 0;
    logic flip = 0;
    logic src_bit;
    logic [2:0] rnd_q = 3'h0;
    logic [7:0] reg_rdata;
    logic [3:0] live_test_flag;
    logic [3:0] latched_test_flag;
    logic [31:0] seed = 32'h00016240;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] rmask [8] = '{8'hBF, 8'hFF, 8'hFF, 8'h0F, 8'h07, 8'h07,
                              8'hF7, 8'h00};
    always #5 clk = ~clk;
    pattern_source src (.clk(clk), .word(20'h570FF), .wide(wide),
        .flip(flip), .bit_out(src_bit));
    rx_lane_pattern_verifier dut (.clk(clk), .rst_b(rst_b),
        .reg_req(reg_req), .reg_rdata(reg_rdata),
        .rx_bits({rnd_q, src_bit}), .dp_events(dp_events),
        .deskew_complete(deskew_complete),
        .live_test_flag(live_test_flag),
        .latched_test_flag(latched_test_flag));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    always @(posedge clk)
        rnd_q <= 3'(xs());
    task automatic chk(input string n, input logic [11:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic rc(input string n, input logic [7:0] a, e);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        reg_req <= '0;
        #1 chk(n, {4'h0, reg_rdata}, {4'h0, e});
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial
    begin
        logic [7:0] d;
        logic [19:0] m;
        int n;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        // ====================
        // register map
        for (int a = 0; a < 8; a++)
            rc("reset", 8'h10 + 8'(a), 8'h00);
        deskew_complete <= 1'b1;
        for (int a = 0; a < 8; a++)
        begin
            d = 8'(xs()) & (a == 5 ? 8'hE7 : 8'hFF);
            wr(8'h10 + 8'(a), d);
            rc("reg", 8'h10 + 8'(a), (d & rmask[a]) |
                (a == 5 ? 8'h80 : 8'h00));
        end
        rc("unmapped", 8'h3C, 8'h00);
        // ====================
        // custom word, 16 and 20 bit
        wr(ADDR_DP_CTRL, 8'h00);
        wr(ADDR_CUSTOM_LOW, 8'hFF);
        wr(ADDR_CUSTOM_MID, 8'h70);
        wr(ADDR_CUSTOM_TOP, 8'h05);
        wr(ADDR_THRESHOLD, 8'h07);
        for (int w = 0; w < 2; w++)
        begin
            wide <= w[0];
            wr(ADDR_MODE, {w[0], 7'h03});
            wr(ADDR_LOAD, 8'h01);
            wr(ADDR_LOAD, 8'h00);
            wr(ADDR_CLEAR_SEL, 8'h00);
            wr(ADDR_CLEAR_SEL, 8'h10);
            repeat (100) @(posedge clk);
            n = 1 + int'(xs() % 4);
            for (int i = 0; i < n; i++)
            begin
                flip <= 1'b1;
                @(posedge clk);
                flip <= 1'b0;
                repeat (30) @(posedge clk);
            end
            wr(ADDR_CLEAR_SEL, 8'h10);
            rc("count_lo", ADDR_COUNT_BASE, 8'(n));
            rc("count_hi", 8'h19, 8'h00);
            chk("flags", 12'({latched_test_flag, live_test_flag}),
                12'h010);
            wr(ADDR_CLEAR_SEL, 8'h18);
            repeat (3) @(posedge clk);
            chk("cleared", 12'(latched_test_flag), 12'h000);
        end
        // ====================
        // data-path error sources
        for (int s = 0; s < 6; s++)
        begin
            m = (s < 5) ? 20'h1 << (4 * (4 - s)) : 20'h0;
            wr(ADDR_DP_CTRL, 8'h10 | 8'(s));
            wr(ADDR_CLEAR_SEL, 8'h00);
            wr(ADDR_CLEAR_SEL, 8'h10);
            for (int i = 0; i < 6; i++)
            begin
                dp_events <= (20'(xs()) & ~m) | (i[0] ? m : 20'h0);
                @(posedge clk);
            end
            dp_events <= '0;
            repeat (4) @(posedge clk);
            rc("dp", ADDR_COUNT_BASE, s < 5 ? 8'h03 : 8'h00);
        end
        end_sim();
    end
endmodule
`default_nettype wire
